// file: signal_trace_recorder.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module signal_trace_recorder
  import trace_rec_pkg::*;
#(
  parameter int MAX_SMP = trace_rec_pkg::MAX_SAMPLES,
  parameter int DEPTH = trace_rec_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [trace_rec_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [trace_rec_pkg::DATA_W-1:0] i_wdata,
  input wire logic [trace_rec_pkg::STRB_W-1:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [trace_rec_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [trace_rec_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // Card signals
  input wire logic i_online,
  input wire logic i_tick_4ms,
  input wire logic i_dither_smp,
  input wire logic [trace_rec_pkg::N_SIG*trace_rec_pkg::SAMPLE_W-1:0] i_sig,
  // Sample stream to service link
  output logic o_st_valid,
  input wire logic i_st_ready,
  output logic [trace_rec_pkg::CH_W+trace_rec_pkg::SAMPLE_W-1:0] o_st_data,
  // Nonvolatile parameter store
  output logic o_nv_we,
  output logic [trace_rec_pkg::ADDR_W-1:0] o_nv_addr,
  output logic [trace_rec_pkg::DATA_W-1:0] o_nv_data
);
  import trace_rec_pkg::*;

  localparam int DW = CH_W + SAMPLE_W;
  localparam logic [IVL_W-1:0] IVL_ONE = 14'h0001;
  localparam logic [IVL_W-1:0] IVL_MAX = IVL_W'(MAX_TICKS);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MAX_SMP);

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] n, input logic [STRB_W-1:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < STRB_W; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic rst_q1;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  rec_state_e state_q;
  logic [CNT_W-1:0] count_q;
  logic [N_CH-1:0] chen_q;
  logic [N_CH*SEL_W-1:0] sel_q;
  logic [TRIG_W-1:0] trig_q;
  logic [IVL_W-1:0] ivl_q;
  logic [DATA_W-1:0] scale_q [N_CH];

  // Write channel capture
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_ok;
  logic [DATA_W-1:0] wv;
  logic cfg_wr;
  logic cmd_new;
  logic cmd_start;
  logic cmd_stop;
  logic clr_all;
  logic go;

  assign o_awready = !aw_hold_q;
  assign o_wready = !w_hold_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (i_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write decode; bad interval values are refused
  always_comb begin
    wr_ok = 1'b1;
    wv = merge('0, wdata_q, wstrb_q);
    if (awaddr_q == A_CTRL) begin
      wv = merge('0, wdata_q, wstrb_q);
    end else if (awaddr_q == A_CHEN) begin
      wv = merge(DATA_W'(chen_q), wdata_q, wstrb_q);
    end else if (awaddr_q == A_SEL) begin
      wv = merge(DATA_W'(sel_q), wdata_q, wstrb_q);
    end else if (awaddr_q == A_TRIG) begin
      wv = merge(DATA_W'(trig_q), wdata_q, wstrb_q);
    end else if (awaddr_q == A_IVL) begin
      wv = merge(DATA_W'(ivl_q), wdata_q, wstrb_q);
      wr_ok = (wv >= DATA_W'(IVL_ONE)) && (wv <= DATA_W'(IVL_MAX));
    end else if (awaddr_q >= A_SCALE0 &&
                 awaddr_q < A_SCALE0 + ADDR_W'(N_CH) * A_SCALE_STEP &&
                 awaddr_q[1:0] == 2'h0) begin
      wv = merge(scale_q[awaddr_q[3:2]], wdata_q, wstrb_q);
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Config edits accepted also offline
  assign cfg_wr = wr_fire && wr_ok && awaddr_q != A_CTRL;
  assign cmd_new = wr_fire && awaddr_q == A_CTRL && wv[CTRL_NEW];
  assign cmd_start = wr_fire && awaddr_q == A_CTRL && wv[CTRL_START];
  assign cmd_stop = wr_fire && awaddr_q == A_CTRL && wv[CTRL_STOP];
  assign clr_all = cmd_new || cfg_wr;
  assign go = i_online && !cmd_stop && !clr_all;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      chen_q <= CHEN_RST;
      sel_q <= SEL_RST;
      trig_q <= TRIG_RST;
      ivl_q <= IVL_RST;
      for (int c = 0; c < N_CH; c++) begin
        scale_q[c] <= SCALE_RST;
      end
    end else if (cfg_wr) begin
      if (awaddr_q == A_CHEN) begin
        chen_q <= wv[N_CH-1:0];
      end else if (awaddr_q == A_SEL) begin
        sel_q <= wv[N_CH*SEL_W-1:0];
      end else if (awaddr_q == A_TRIG) begin
        trig_q <= wv[TRIG_W-1:0];
      end else if (awaddr_q == A_IVL) begin
        ivl_q <= wv[IVL_W-1:0];
      end else begin
        scale_q[awaddr_q[3:2]] <= wv;
      end
    end
  end

  // Settings mirrored to the parameter store; samples never go there
  logic nv_we_q;
  logic [ADDR_W-1:0] nv_addr_q;
  logic [DATA_W-1:0] nv_data_q;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_we_q <= 1'b0;
      nv_addr_q <= '0;
      nv_data_q <= '0;
    end else begin
      nv_we_q <= cfg_wr;
      if (cfg_wr) begin
        nv_addr_q <= awaddr_q;
        nv_data_q <= wv;
      end
    end
  end
  assign o_nv_we = nv_we_q;
  assign o_nv_addr = nv_addr_q;
  assign o_nv_data = nv_data_q;

  // Solenoid currents averaged per dither period
  localparam int ACC_W = SAMPLE_W + DITHER_SHIFT;
  logic [ACC_W-1:0] acc_q [2];
  logic [SAMPLE_W-1:0] avg_q [2];
  logic [DITHER_SHIFT-1:0] dcnt_q;
  logic [SAMPLE_W-1:0] eff_sig [N_SIG];
  logic [ACC_W-1:0] acc_n [2];

  always_comb begin
    for (int s = 0; s < N_SIG; s++) begin
      eff_sig[s] = i_sig[s*SAMPLE_W +: SAMPLE_W];
    end
    acc_n[0] = acc_q[0] + ACC_W'(eff_sig[SOL_A_SEL]);
    acc_n[1] = acc_q[1] + ACC_W'(eff_sig[SOL_B_SEL]);
    eff_sig[SOL_A_SEL] = avg_q[0];
    eff_sig[SOL_B_SEL] = avg_q[1];
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_q <= '0;
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      avg_q[0] <= '0;
      avg_q[1] <= '0;
    end else if (i_dither_smp) begin
      dcnt_q <= dcnt_q + 1'b1;
      for (int k = 0; k < 2; k++) begin
        if (&dcnt_q) begin
          avg_q[k] <= acc_n[k][ACC_W-1:DITHER_SHIFT];
          acc_q[k] <= '0;
        end else begin
          acc_q[k] <= acc_n[k];
        end
      end
    end
  end

  // Trigger detection
  logic [SAMPLE_W-1:0] trig_val;
  logic above;
  logic above_q;
  logic trig_hit;
  logic strobe;
  logic take;
  logic [IVL_W-1:0] ivl_cnt_q;

  assign trig_val =
    eff_sig[sel_q[trig_q[TRIG_CH_LSB +: CH_W]*SEL_W +: SEL_W]];
  assign above = trig_val >= trig_q[TRIG_LVL_LSB +: SAMPLE_W];
  assign trig_hit = state_q == ST_ARMED && (trig_q[TRIG_RISE] ?
    (above && !above_q) : (!above && above_q));
  assign strobe = state_q == ST_RUN && i_tick_4ms &&
    ivl_cnt_q == ivl_q - IVL_ONE;
  assign take = (trig_hit || strobe) && go;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      above_q <= 1'b0;
    end else begin
      above_q <= above;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ivl_cnt_q <= '0;
    end else if (trig_hit) begin
      ivl_cnt_q <= '0;
    end else if (state_q == ST_RUN && i_tick_4ms) begin
      ivl_cnt_q <= strobe ? '0 : ivl_cnt_q + IVL_ONE;
    end
  end

  // Recording state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (clr_all || !i_online || cmd_stop) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_start && count_q < CNT_MAX) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (trig_hit) begin
            state_q <= (count_q + 1'b1 == CNT_MAX) ? ST_FULL : ST_RUN;
          end
        end
        ST_RUN: begin
          if (strobe && count_q + 1'b1 == CNT_MAX) begin
            state_q <= ST_FULL;
          end
        end
        default: begin
          state_q <= ST_FULL;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clr_all) begin
      count_q <= '0;
    end else if (take) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Snapshot and serialise enabled channels
  logic [SAMPLE_W-1:0] snap_q [N_CH];
  logic [N_CH-1:0] pend_q;
  logic [CH_W-1:0] pick;
  logic push_ready;
  logic fifo_valid;

  always_comb begin
    pick = '0;
    for (int c = N_CH - 1; c >= 0; c--) begin
      if (pend_q[c]) begin
        pick = CH_W'(c);
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
      for (int c = 0; c < N_CH; c++) begin
        snap_q[c] <= '0;
      end
    end else if (clr_all) begin
      pend_q <= '0;
    end else if (take) begin
      pend_q <= chen_q;
      for (int c = 0; c < N_CH; c++) begin
        snap_q[c] <= eff_sig[sel_q[c*SEL_W +: SEL_W]];
      end
    end else if (|pend_q && push_ready) begin
      pend_q[pick] <= 1'b0;
    end
  end

  trace_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_flush(clr_all),
    .i_valid(|pend_q),
    .o_ready(push_ready),
    .i_data({pick, snap_q[pick]}),
    .o_valid(fifo_valid),
    .i_ready(i_st_ready && state_q != ST_IDLE),
    .o_data(o_st_data)
  );
  // Draining continues when full, halts when idle
  assign o_st_valid = fifo_valid && state_q != ST_IDLE;

  // Read channel
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      if (i_araddr == A_CTRL) begin
        rdata_q[CTRL_ONLINE] <= i_online;
      end else if (i_araddr == A_CHEN) begin
        rdata_q <= DATA_W'(chen_q);
      end else if (i_araddr == A_SEL) begin
        rdata_q <= DATA_W'(sel_q);
      end else if (i_araddr == A_TRIG) begin
        rdata_q <= DATA_W'(trig_q);
      end else if (i_araddr == A_IVL) begin
        rdata_q <= DATA_W'(ivl_q);
      end else if (i_araddr == A_STAT) begin
        rdata_q[STAT_CNT_LSB +: CNT_W] <= count_q;
        rdata_q[STAT_ST_LSB +: 2] <= state_q;
      end else if (i_araddr >= A_SCALE0 &&
                   i_araddr < A_SCALE0 + ADDR_W'(N_CH) * A_SCALE_STEP &&
                   i_araddr[1:0] == 2'h0) begin
        rdata_q <= scale_q[i_araddr[3:2]];
      end else begin
        rresp_q <= RESP_SLVERR;
      end
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  chk_count_limit: assert property (count_q <= CNT_MAX)
    else $error("sample count above limit");
  chk_full_frozen: assert property (state_q == ST_FULL && !clr_all
    |=> $stable(count_q))
    else $error("count moved while full");
  chk_pend_enabled: assert property ((pend_q & ~chen_q) == '0)
    else $error("disabled channel pending");
  chk_ivl_range: assert property (ivl_q >= IVL_ONE && ivl_q <= IVL_MAX)
    else $error("interval out of range");
  chk_trig_sample: assert property (trig_hit && go
    |=> count_q == $past(count_q) + 1'b1 && pend_q == $past(chen_q))
    else $error("no sample at trigger");
  chk_armed_quiet: assert property (state_q == ST_ARMED && !trig_hit
    |-> !take)
    else $error("sample before trigger");
  chk_new_clears: assert property (cmd_new
    |=> count_q == '0 && state_q == ST_IDLE && !o_st_valid)
    else $error("new did not clear");
  chk_start_append: assert property (state_q == ST_IDLE && cmd_start && go
    && count_q < CNT_MAX |=> state_q == ST_ARMED && $stable(count_q))
    else $error("start did not append");
  chk_stop_halts: assert property (cmd_stop
    |=> state_q == ST_IDLE && !o_st_valid)
    else $error("stop did not halt");
  chk_offline_idle: assert property (!i_online |=> state_q == ST_IDLE)
    else $error("capture while offline");
  chk_cfg_clear: assert property (cfg_wr
    |=> (count_q == '0 && o_nv_we) ##1 !o_nv_we)
    else $error("config change kept samples");
  chk_strobe_gap: assert property (strobe
    |=> ivl_cnt_q == '0 && !strobe)
    else $error("interval count not restarted");

  cov_trigger: cover property (state_q == ST_ARMED ##1 state_q == ST_RUN);
  cov_full: cover property (state_q == ST_RUN ##1 state_q == ST_FULL);
  cov_backpressure: cover property (|pend_q && !push_ready);
  cov_restart: cover property (state_q == ST_IDLE && count_q != '0
    ##1 state_q == ST_ARMED);
endmodule

// file: trace_rec_pkg.sv
package trace_rec_pkg;
  localparam int N_CH = 4;
  localparam int CH_W = 2;
  localparam int SAMPLE_W = 16;
  localparam int N_SIG = 16;
  localparam int SEL_W = 4;
  localparam int CNT_W = 8;
  localparam int MAX_SAMPLES = 250;
  localparam int FIFO_DEPTH = 8;
  localparam int TICK_MS = 4;
  localparam int MAX_INTERVAL_MS = 60000;
  localparam int MAX_TICKS = MAX_INTERVAL_MS / TICK_MS;
  localparam int IVL_W = 14;
  localparam int DITHER_SHIFT = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_CHEN = 8'h04;
  localparam logic [ADDR_W-1:0] A_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] A_TRIG = 8'h0c;
  localparam logic [ADDR_W-1:0] A_IVL = 8'h10;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] A_SCALE0 = 8'h20;
  localparam logic [ADDR_W-1:0] A_SCALE_STEP = 8'h04;

  localparam int CTRL_NEW = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_ONLINE = 3;
  localparam int TRIG_LVL_LSB = 0;
  localparam int TRIG_CH_LSB = 16;
  localparam int TRIG_RISE = 18;
  localparam int TRIG_W = 19;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_ST_LSB = 8;

  localparam logic [N_CH-1:0] CHEN_RST = 4'h1;
  localparam logic [N_CH*SEL_W-1:0] SEL_RST = 16'h3210;
  localparam logic [TRIG_W-1:0] TRIG_RST = 19'h40000;
  localparam logic [IVL_W-1:0] IVL_RST = 14'h0001;
  localparam logic [DATA_W-1:0] SCALE_RST = 32'h00010000;
  localparam logic [SEL_W-1:0] SOL_A_SEL = 4'he;
  localparam logic [SEL_W-1:0] SOL_B_SEL = 4'hf;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_FULL} rec_state_e;
endpackage

// file: trace_fifo.sv
`timescale 1ns/1ps
module trace_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (i_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (i_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= i_data;
    end
  end
endmodule

// file: link_sink.sv
`timescale 1ns/1ps
module link_sink
  import trace_rec_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pace control
  input wire logic i_stall,
  input wire logic i_slow,
  // Sample stream
  input wire logic i_valid,
  input wire logic [trace_rec_pkg::CH_W+trace_rec_pkg::SAMPLE_W-1:0] i_data,
  output logic o_ready
);
  logic [CH_W+SAMPLE_W-1:0] rx [0:63];
  int rx_n;
  // Host log of the last 64 words, in arrival order
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      rx_n <= 0;
    end else begin
      if (i_valid && o_ready) begin
        rx[rx_n[5:0]] <= i_data;
        rx_n <= rx_n + 1;
      end
      o_ready <= !i_stall && !(i_slow && o_ready);
    end
  end
endmodule

// file: tb_signal_trace_recorder.sv
`timescale 1ns/1ps
module tb_signal_trace_recorder;
  import trace_rec_pkg::*;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic online = 1, tick = 0, dith = 0, stall = 0, slow = 0;
  logic [7:0] awa = 0, ara = 0, nva, nva_l;
  logic [31:0] wd = 0, rd, rdat, nvd, nvd_l;
  logic [255:0] sig = 0;
  logic awr, wr_r, bv, arr, rv, stv, sr, nvwe;
  logic [1:0] bresp, rresp, rsp;
  logic [17:0] std;
  int n_errors = 0, num_checks = 0, cyc = 0, nv_n = 0, b;

  signal_trace_recorder #(.MAX_SMP(3), .DEPTH(8)) u_signal_trace_recorder (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_awprot(3'h0),
    .i_wvalid(wv), .o_wready(wr_r), .i_wdata(wd), .i_wstrb(4'hf),
    .o_bvalid(bv), .i_bready(br), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0),
    .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp),
    .i_online(online), .i_tick_4ms(tick), .i_dither_smp(dith), .i_sig(sig),
    .o_st_valid(stv), .i_st_ready(sr), .o_st_data(std),
    .o_nv_we(nvwe), .o_nv_addr(nva), .o_nv_data(nvd));

  link_sink u_link_sink (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
    .i_slow(slow), .i_valid(stv), .i_data(std), .o_ready(sr));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Store monitor, sampled away from the launching edge
  always @(negedge clk) begin
    if (nvwe) begin
      nv_n++;
      nva_l = nva;
      nvd_l = nvd;
    end
  end

  // Tick every 20 cycles, dither sample every 4; timeout
  always @(posedge clk) begin
    cyc++;
    tick <= (cyc % 20 == 0);
    dith <= (cyc % 4 == 0);
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, tk;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr_r;
      tk = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tk);
    br <= 0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 0;
    end while (!tr);
    rr <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    axw(a, d, rsp);
    chk(rsp, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rsp);
    chk(rd, e);
  endtask

  task automatic stat(input logic [7:0] c, input logic [1:0] s);
    axr(A_STAT, rd, rsp);
    chk(rd, {22'h0, s, c});
  endtask

  task automatic st(input logic [1:0] s);
    axr(A_STAT, rd, rsp);
    chk(rd[9:8], s);
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 300 && u_link_sink.rx_n < n; i++) @(negedge clk);
    chk(u_link_sink.rx_n, n);
  endtask

  task automatic t_regs();
    rdc(A_CHEN, 32'h1);
    rdc(A_SEL, 32'h3210);
    rdc(A_TRIG, 32'h40000);
    rdc(A_IVL, 32'h1);
    rdc(A_SCALE0, 32'h10000);
    rdc(A_CTRL, 32'h8);
    stat(8'h0, 2'h0);
    axr(8'h40, rd, rsp);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_cfg();
    b = nv_n;
    wr(A_SCALE0 + A_SCALE_STEP, 32'h20003, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(nv_n, b + 1);
    chk(nva_l, A_SCALE0 + A_SCALE_STEP);
    chk(nvd_l, 32'h20003);
    wr(A_IVL, 32'h0, RESP_SLVERR);
    wr(A_IVL, 32'h3a99, RESP_SLVERR);
    rdc(A_IVL, 32'h1);
    chk(nv_n, b + 1);
    wr(A_IVL, 32'h3a98, RESP_OKAY);
    rdc(A_IVL, 32'h3a98);
    $display("t_cfg done");
  endtask

  task automatic t_full();
    int k;
    b = u_link_sink.rx_n;
    stall <= 1;
    wr(A_CHEN, 32'h3, RESP_OKAY);
    wr(A_SEL, 32'h32, RESP_OKAY);
    wr(A_TRIG, 32'h40100, RESP_OKAY);
    wr(A_IVL, 32'h2, RESP_OKAY);
    sig[47:32] <= 16'h0050;
    sig[63:48] <= 16'h1234;
    wr(A_CTRL, 32'h2, RESP_OKAY);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(stv, 1'b0);
    stat(8'h0, 2'h1);
    sig[47:32] <= 16'h0200;
    repeat (15) @(posedge clk);
    stat(8'h1, 2'h2);
    repeat (25) @(posedge clk);
    stat(8'h2, 2'h2);
    for (k = 0; k < 40 && rd[7:0] !== 8'h3; k++) axr(A_STAT, rd, rsp);
    stat(8'h3, 2'h3);
    axw(A_CTRL, 32'h2, rsp);
    stat(8'h3, 2'h3);
    chk(u_link_sink.rx_n, b);
    stall <= 0;
    wait_rx(b + 6);
    for (k = 0; k < 6; k++) begin
      chk(u_link_sink.rx[b + k], k[0] ? 32'h11234 : 32'h200);
    end
    $display("t_full done");
  endtask

  task automatic t_new_stop();
    wr(A_CTRL, 32'h1, RESP_OKAY);
    stat(8'h0, 2'h0);
    sig[47:32] <= 16'h0050;
    wr(A_CTRL, 32'h2, RESP_OKAY);
    stat(8'h0, 2'h1);
    sig[47:32] <= 16'h0200;
    repeat (4) @(posedge clk);
    stat(8'h1, 2'h2);
    wr(A_CTRL, 32'h4, RESP_OKAY);
    stat(8'h1, 2'h0);
    sig[47:32] <= 16'h0050;
    wr(A_CTRL, 32'h2, RESP_OKAY);
    stat(8'h1, 2'h1);
    sig[47:32] <= 16'h0200;
    repeat (4) @(posedge clk);
    stat(8'h2, 2'h2);
    $display("t_new_stop done");
  endtask

  task automatic t_offline();
    b = nv_n;
    online <= 0;
    repeat (3) @(posedge clk);
    st(2'h0);
    rdc(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h2, RESP_OKAY);
    st(2'h0);
    wr(A_TRIG, 32'h52000, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(nv_n, b + 1);
    stat(8'h0, 2'h0);
    online <= 1;
    repeat (3) @(posedge clk);
    rdc(A_TRIG, 32'h52000);
    $display("t_offline done");
  endtask

  task automatic t_sol();
    b = u_link_sink.rx_n;
    slow <= 1;
    sig[239:224] <= 16'h0abc;
    wr(A_SEL, 32'h3e, RESP_OKAY);
    wr(A_CTRL, 32'h2, RESP_OKAY);
    repeat (130) @(posedge clk);
    sig[63:48] <= 16'h3000;
    wait_rx(b + 2);
    chk(u_link_sink.rx[b], 32'habc);
    chk(u_link_sink.rx[b + 1], 32'h13000);
    wr(A_TRIG, 32'h12000, RESP_OKAY);
    wr(A_CTRL, 32'h2, RESP_OKAY);
    stat(8'h0, 2'h1);
    sig[63:48] <= 16'h1000;
    wait_rx(b + 4);
    chk(u_link_sink.rx[b + 2], 32'habc);
    chk(u_link_sink.rx[b + 3], 32'h11000);
    $display("t_sol done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_regs();
    t_cfg();
    t_full();
    t_new_stop();
    t_offline();
    t_sol();
    finish_test();
  end
endmodule
